// [hw/hidc_consts.vh]
// Constants for the interrupt disable and communication area register bank
`ifndef HIDC_CONSTS_VH
`define HIDC_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HIDC_OFS_INT_ENABLE     8'h10
`define HIDC_OFS_INT_DISABLE    8'h14
`define HIDC_OFS_COMM_AREA_BASE 8'h18
`define HIDC_OFS_EVENT_STATUS   8'h40

// ----------------------------------------
// Field positions
// ----------------------------------------
`define HIDC_BIT_MASTER_IRQ_GATE 31
`define HIDC_BIT_OWNERSHIP       30
`define HIDC_BIT_ROOT_HUB        6
`define HIDC_BIT_FRAME_OVF       5
`define HIDC_BIT_FATAL_ERROR     4
`define HIDC_BIT_RESUME          3
`define HIDC_BIT_FRAME_START     2
`define HIDC_BIT_DONE_HEAD       1
`define HIDC_BIT_SCHED_OVERRUN   0
`define HIDC_BASE_MSB            31
`define HIDC_BASE_LSB            8
`define HIDC_BASE_W              24
`define HIDC_NUM_EVENTS          8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HIDC_RST_BASE   24'h000000
`define HIDC_RST_WORD   32'h00000000
`define HIDC_LOW_ZERO   8'h00

`endif

// [hw/hidc_event_bit.v]
// One event source: enable bit and sticky status bit
`timescale 1ns/1ps

module hidc_event_bit (
	input  wire clock_i,
	input  wire rst_b_i,
	input  wire soft_reset_i,
	input  wire enable_set_i,
	input  wire enable_clr_i,
	input  wire event_i,
	input  wire status_clr_i,
	output reg  enable_o,
	output reg  status_o
);

	// ----------------------------------------
	// Enable bit
	// ----------------------------------------
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			enable_o <= 1'b0;
		end else if (soft_reset_i) begin
			enable_o <= 1'b0;
		end else if (enable_clr_i) begin
			enable_o <= 1'b0;
		end else if (enable_set_i) begin
			enable_o <= 1'b1;
		end
	end

	// ----------------------------------------
	// Sticky status, set wins over clear
	// ----------------------------------------
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			status_o <= 1'b0;
		end else if (soft_reset_i) begin
			status_o <= 1'b0;
		end else if (event_i) begin
			status_o <= 1'b1;
		end else if (status_clr_i) begin
			status_o <= 1'b0;
		end
	end

endmodule

// [hw/hidc_regs.v]
// Interrupt enable/disable and communication area base register bank
// Overview of operation
// - Writing 1 to bit 31 gates off all event interrupts; zeros change nothing.
// - Hardware or software reset leaves the master gate closed, no interrupts.
// - Writing 1 to bit 30 stops ownership change interrupts.
// - Writing 1 to bit 6 stops root hub change interrupts.
// - Writing 1 to bit 5 stops frame counter overflow interrupts.
// - Writing 1 to bit 4 stops fatal error interrupts.
// - Writing 1 to bit 3 stops resume detect interrupts.
// - Writing 1 to bit 2 stops start of frame interrupts.
// - Bit 1 stops done head write-back, bit 0 scheduling overrun interrupts.
// - Base address field bits 31 to 8 is read/write.
// - Base is 256-byte aligned; bits 7 to 0 always read zero.
// - Addressed area holds structures shared by controller and driver.
// - Each 1 written to disable clears the matching enable bit.
// - Reading disable returns the current enable register contents.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "hidc_consts.vh"

module hidc_regs #(
	parameter ADDR_W = 8
) (
	input  wire              clock_i,
	input  wire              rst_b_i,
	input  wire              soft_reset_i,
	input  wire [ADDR_W-1:0] addr_i,
	input  wire [31:0]       wr_data_i,
	input  wire              wr_strobe_i,
	input  wire              rd_strobe_i,
	input  wire              ev_sched_overrun_i,
	input  wire              ev_done_head_written_i,
	input  wire              ev_frame_start_i,
	input  wire              ev_resume_i,
	input  wire              ev_fatal_error_i,
	input  wire              ev_frame_count_overflow_i,
	input  wire              ev_root_hub_change_i,
	input  wire              ev_ownership_change_i,
	output reg  [31:0]       rd_data_o,
	output reg               irq_o,
	output reg               master_irq_gate_o,
	output reg  [23:0]       comm_area_base_o
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire        hit_enable;
	wire        hit_disable;
	wire        hit_base;
	wire        hit_status;
	wire        wr_enable;
	wire        wr_disable;
	wire        wr_base;
	wire        wr_status;

	assign hit_enable  = (addr_i == `HIDC_OFS_INT_ENABLE);
	assign hit_disable = (addr_i == `HIDC_OFS_INT_DISABLE);
	assign hit_base    = (addr_i == `HIDC_OFS_COMM_AREA_BASE);
	assign hit_status  = (addr_i == `HIDC_OFS_EVENT_STATUS);
	assign wr_enable   = wr_strobe_i & hit_enable;
	assign wr_disable  = wr_strobe_i & hit_disable;
	assign wr_base     = wr_strobe_i & hit_base;
	assign wr_status   = wr_strobe_i & hit_status;

	// ----------------------------------------
	// Event sources in register bit order
	// ----------------------------------------
	wire [`HIDC_NUM_EVENTS-1:0] ev_pulse;
	wire [`HIDC_NUM_EVENTS-1:0] en_bits;
	wire [`HIDC_NUM_EVENTS-1:0] st_bits;
	wire [`HIDC_NUM_EVENTS-1:0] wr_bits;

	assign ev_pulse = {ev_ownership_change_i,
	                   ev_root_hub_change_i,
	                   ev_frame_count_overflow_i,
	                   ev_fatal_error_i,
	                   ev_resume_i,
	                   ev_frame_start_i,
	                   ev_done_head_written_i,
	                   ev_sched_overrun_i};

	// Only bits 30 and 6..0 reach an event; reserved bits are dropped
	assign wr_bits = {wr_data_i[`HIDC_BIT_OWNERSHIP],
	                  wr_data_i[`HIDC_BIT_ROOT_HUB:`HIDC_BIT_SCHED_OVERRUN]};

	// ----------------------------------------
	// Per-event enable and status
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `HIDC_NUM_EVENTS; gi = gi + 1) begin : g_ev
			hidc_event_bit u_bit (
				.clock_i      (clock_i),
				.rst_b_i      (rst_b_i),
				.soft_reset_i (soft_reset_i),
				.enable_set_i (wr_enable & wr_bits[gi]),
				.enable_clr_i (wr_disable & wr_bits[gi]),
				.event_i      (ev_pulse[gi]),
				.status_clr_i (wr_status & wr_bits[gi]),
				.enable_o     (en_bits[gi]),
				.status_o     (st_bits[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Master gate
	// ----------------------------------------
	reg master_gate;

	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			master_gate <= 1'b0;
		end else if (soft_reset_i) begin
			master_gate <= 1'b0;
		end else if (wr_disable && wr_data_i[`HIDC_BIT_MASTER_IRQ_GATE]) begin
			master_gate <= 1'b0;
		end else if (wr_enable && wr_data_i[`HIDC_BIT_MASTER_IRQ_GATE]) begin
			master_gate <= 1'b1;
		end
	end

	// ----------------------------------------
	// Assembled register words
	// ----------------------------------------
	wire [31:0] enable_word;
	wire [31:0] status_word;

	assign enable_word = {master_gate, en_bits[7], 23'h000000, en_bits[6:0]};
	assign status_word = {1'b0, st_bits[7], 23'h000000, st_bits[6:0]};

	// ----------------------------------------
	// Communication area base
	// ----------------------------------------
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			comm_area_base_o <= `HIDC_RST_BASE;
		end else if (soft_reset_i) begin
			comm_area_base_o <= `HIDC_RST_BASE;
		end else if (wr_base) begin
			comm_area_base_o <= wr_data_i[`HIDC_BASE_MSB:`HIDC_BASE_LSB];
		end
	end

	// ----------------------------------------
	// Read data, one cycle after the strobe
	// ----------------------------------------
	reg [31:0] next_rd_data;

	always @* begin
		next_rd_data = `HIDC_RST_WORD;
		if (rd_strobe_i) begin
			case (1'b1)
				hit_enable:  next_rd_data = enable_word;
				hit_disable: next_rd_data = enable_word;
				hit_base:    next_rd_data = {comm_area_base_o, `HIDC_LOW_ZERO};
				hit_status:  next_rd_data = status_word;
				default:     next_rd_data = `HIDC_RST_WORD;
			endcase
		end
	end

	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_data_o <= `HIDC_RST_WORD;
		end else begin
			rd_data_o <= next_rd_data;
		end
	end

	// ----------------------------------------
	// Interrupt output
	// ----------------------------------------
	wire next_irq;

	assign next_irq = master_gate & (|(en_bits & st_bits));

	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_o             <= 1'b0;
			master_irq_gate_o <= 1'b0;
		end else begin
			irq_o             <= next_irq;
			master_irq_gate_o <= master_gate;
		end
	end

endmodule

// [tb/hidc_regs_checker.sv]
// Assertions on the interrupt disable and comm area register bank
`timescale 1ns/1ps
module hidc_regs_checker #(
	parameter ADDR_W = 8
) (
	input logic              clock_i,
	input logic              rst_b_i,
	input logic              soft_reset_i,
	input logic [ADDR_W-1:0] addr_i,
	input logic [31:0]       wr_data_i,
	input logic              wr_strobe_i,
	input logic              rd_strobe_i,
	input logic [31:0]       rd_data_o,
	input logic              irq_o,
	input logic              master_irq_gate_o,
	input logic [23:0]       comm_area_base_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	property p_mst_off; wr_strobe_i && addr_i == 8'h14 && wr_data_i[31] |-> ##2 !master_irq_gate_o;
	endproperty
	a_mst_off: assert property (p_mst_off) else $error("gate not closed");
	property p_gated; !master_irq_gate_o |-> !irq_o; endproperty
	a_gated: assert property (p_gated) else $error("irq while gated");
	property p_soft; soft_reset_i |=> comm_area_base_o == 24'h0 ##1 !master_irq_gate_o; endproperty
	a_soft: assert property (p_soft) else $error("soft reset missed");
	property p_base_wr; wr_strobe_i && addr_i == 8'h18 && !soft_reset_i
		|=> comm_area_base_o == $past(wr_data_i[31:8]); endproperty
	a_base_wr: assert property (p_base_wr) else $error("base not stored");
	property p_base_rd; $past(rd_strobe_i) && $past(addr_i) == 8'h18
		|-> rd_data_o == {$past(comm_area_base_o), 8'h00}; endproperty
	a_base_rd: assert property (p_base_rd) else $error("base read wrong");
	property p_rsv; $past(rd_strobe_i) && $past(addr_i) == 8'h14 |-> rd_data_o[29:7] == 23'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_mirror; $past(rd_strobe_i) && $past(addr_i) == 8'h14
		|-> rd_data_o[31] == master_irq_gate_o; endproperty
	a_mirror: assert property (p_mirror) else $error("disable read mismatch");
	property p_clr; $past(rd_strobe_i) && $past(addr_i) == 8'h14 && !$past(wr_strobe_i, 2)
		&& $past(wr_strobe_i, 3) && $past(addr_i, 3) == 8'h14
		|-> (rd_data_o & $past(wr_data_i, 3)) == 32'h0; endproperty
	a_clr: assert property (p_clr) else $error("enable not cleared");
	c_irq: cover property (irq_o);
	c_soft: cover property (soft_reset_i);
	c_clr: cover property ($past(rd_strobe_i) && $past(addr_i) == 8'h14
		&& $past(wr_strobe_i, 3) && $past(addr_i, 3) == 8'h14);
endmodule
bind hidc_regs hidc_regs_checker #(.ADDR_W(ADDR_W)) u_chk (.clock_i(clock_i),
	.rst_b_i(rst_b_i), .soft_reset_i(soft_reset_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
	.wr_strobe_i(wr_strobe_i), .rd_strobe_i(rd_strobe_i), .rd_data_o(rd_data_o),
	.irq_o(irq_o), .master_irq_gate_o(master_irq_gate_o), .comm_area_base_o(comm_area_base_o));

// [tb/tb_top.sv]
// Self-checking bench for the interrupt disable and comm area bank
`timescale 1ns/1ps
module tb_top;
	logic        clock_i = 1'h0;
	logic        rst_b_i = 1'h0;
	logic        soft_reset_i = 1'h0;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wr_data_i = 32'h0;
	logic        wr_strobe_i = 1'h0;
	logic        rd_strobe_i = 1'h0;
	logic [7:0]  ev = 8'h00;
	logic [31:0] rd_data_o;
	logic        irq_o;
	logic        master_irq_gate_o;
	logic [23:0] comm_area_base_o;
	logic [31:0] e;
	int          bits[9] = '{30, 6, 5, 4, 3, 2, 1, 0, 31};
	int          num_errors = 0;
	int          check_count = 0;
	always #5 clock_i = ~clock_i;
	hidc_regs uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .soft_reset_i(soft_reset_i),
		.addr_i(addr_i), .wr_data_i(wr_data_i), .wr_strobe_i(wr_strobe_i),
		.rd_strobe_i(rd_strobe_i), .ev_sched_overrun_i(ev[0]), .ev_done_head_written_i(ev[1]),
		.ev_frame_start_i(ev[2]), .ev_resume_i(ev[3]), .ev_fatal_error_i(ev[4]),
		.ev_frame_count_overflow_i(ev[5]), .ev_root_hub_change_i(ev[6]),
		.ev_ownership_change_i(ev[7]), .rd_data_o(rd_data_o), .irq_o(irq_o),
		.master_irq_gate_o(master_irq_gate_o), .comm_area_base_o(comm_area_base_o));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_i);
		addr_i <= a;
		wr_data_i <= v;
		wr_strobe_i <= 1'h1;
		@(posedge clock_i);
		wr_strobe_i <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		@(posedge clock_i);
		addr_i <= a;
		rd_strobe_i <= 1'h1;
		@(posedge clock_i);
		rd_strobe_i <= 1'h0;
		#1 chk(rd_data_o, x);
	endtask
	task pulse(input logic [7:0] v);
		@(posedge clock_i);
		ev <= v;
		@(posedge clock_i);
		ev <= 8'h00;
	endtask
	task irq(input logic x);
		repeat (3) @(posedge clock_i);
		#1 chk({31'h0, irq_o}, {31'h0, x});
	endtask
	task complete_run;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge clock_i);
		rst_b_i <= 1'h1;
		rd(8'h14, 32'h0);
		rd(8'h18, 32'h0);
		wr(8'h10, 32'hC000007F);
		rd(8'h14, 32'hC000007F);
		wr(8'h14, 32'h3FFFFF80);
		rd(8'h14, 32'hC000007F);
		wr(8'h14, 32'h0);
		rd(8'h14, 32'hC000007F);
		e = 32'hC000007F;
		foreach (bits[i]) begin
			e[bits[i]] = 1'h0;
			wr(8'h14, 32'h1 << bits[i]);
			rd(8'h14, e);
		end
		$display("disable bits done");
		wr(8'h10, 32'h80000004);
		pulse(8'h04);
		irq(1'h1);
		wr(8'h14, 32'h00000004);
		irq(1'h0);
		wr(8'h10, 32'h00000004);
		irq(1'h1);
		wr(8'h14, 32'h80000000);
		irq(1'h0);
		chk({31'h0, master_irq_gate_o}, 32'h0);
		$display("interrupt gating done");
		wr(8'h10, 32'hC000007F);
		pulse(8'hFF);
		rd(8'h40, 32'h4000007F);
		irq(1'h1);
		wr(8'h14, 32'h4000007F);
		irq(1'h0);
		wr(8'h10, 32'h40000000);
		irq(1'h1);
		wr(8'h14, 32'h40000000);
		irq(1'h0);
		rd(8'h40, 32'h4000007F);
		wr(8'h40, 32'h00000001);
		rd(8'h40, 32'h4000007E);
		wr(8'h40, 32'h4000007E);
		rd(8'h40, 32'h0);
		$display("event status done");
		wr(8'h18, 32'hFFFFFFFF);
		rd(8'h18, 32'hFFFFFF00);
		chk({8'h00, comm_area_base_o}, 32'h00FFFFFF);
		wr(8'h18, 32'h12345678);
		wr(8'h24, 32'hFFFFFFFF);
		rd(8'h24, 32'h0);
		rd(8'h18, 32'h12345600);
		$display("base register done");
		wr(8'h10, 32'hC000007F);
		@(posedge clock_i);
		soft_reset_i <= 1'h1;
		@(posedge clock_i);
		soft_reset_i <= 1'h0;
		rd(8'h14, 32'h0);
		rd(8'h18, 32'h0);
		$display("soft reset done");
		wr(8'h18, 32'hABCDEF00);
		wr(8'h10, 32'hC000007F);
		@(posedge clock_i);
		rst_b_i <= 1'h0;
		repeat (2) @(posedge clock_i);
		rst_b_i <= 1'h1;
		#1 chk({8'h00, comm_area_base_o}, 32'h0);
		chk({30'h0, irq_o, master_irq_gate_o}, 32'h0);
		rd(8'h14, 32'h0);
		rd(8'h18, 32'h0);
		$display("hardware reset done");
		complete_run;
	end
endmodule
